// ==== verilog/hrf_pkg.sv ====
package hrf_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_MODE = 5'h00;     // header handling mode
  localparam logic [ADDR_W-1:0] REG_CONTROL_STATUS_2 = 5'h04;     // control_status_2 filter bits
  localparam logic [ADDR_W-1:0] REG_STATION = 5'h08;  // {remote, local} station addresses
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h0C;   // bad count and last frame flags
  localparam logic [ADDR_W-1:0] REG_INIT_BASE = 5'h10; // init_block_base, 24 bits

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_ADDR_EXT_BIT = 6;    // ext_addr_enable
  localparam int MODE_CTRL_EXT_BIT = 7;    // ext_ctrl_enable
  localparam int MODE_HDR_DIS_BIT = 8;     // header_extract_disable
  localparam int MODE_ADDR_FORCE_BIT = 9;  // ext_addr_force
  localparam int MODE_CTRL_FORCE_BIT = 10; // ext_ctrl_force
  localparam int CONTROL_STATUS_2_GLOBAL_BIT = 8;      // global_addr_accept
  localparam int CONTROL_STATUS_2_ALL_BIT = 10;        // accept_all_frames
  localparam int DESC_REMOTE_BIT = 9;      // matched_remote_flag in rx_descriptor_word0
  localparam logic [23:0] BAD_CNT_OFFSET = 24'h00002C; // bad-frame counter, init block + 44
  localparam logic [7:0] GLOBAL_OCTET = 8'hFF;
  localparam logic [31:0] MODE_RST = 32'h00000000;
  localparam logic [31:0] CONTROL_STATUS_2_RST = 32'h00000000;
  localparam logic [31:0] STATION_RST = 32'h00000000;
  localparam logic [23:0] INIT_BASE_RST = 24'h000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic addr_ext;
    logic addr_force;
    logic ctrl_ext;
    logic ctrl_force;
    logic hdr_dis;
    logic accept_all;
    logic global_ok;
  } hrf_cfg_t;

  typedef struct packed {
    logic [15:0] data;   // first octet in the low lane
    logic odd;           // only the low lane is meaningful
    logic hdr_single;    // single header octet copied to both lanes
  } hrf_word_t;

  typedef struct packed {
    logic good;          // aligned and check sequence correct
    logic remote;        // matched the remote station address
    logic command;       // global address, classed as a command
  } hrf_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR1 = 3'b001,
    ST_ADDR2 = 3'b010,
    ST_CTRL1 = 3'b011,
    ST_CTRL2 = 3'b100,
    ST_DATA = 3'b101,
    ST_DROP = 3'b110
  } hrf_state_t;

endpackage

// ==== verilog/hrf_rx_filter.sv ====
`timescale 1ns/1ps
// Function
// - in extended, zero address LSB extends address one octet
// - address field one or two octets
// - control one octet, or two in extended
// - good flag only on good aligned frames; bad ones counted
// - filter on local or remote address
// - descriptor bit 9 shows remote match
// - unmatched frames dropped unless global matches
// - extended control two octets if LSB zero
// - address force makes address two octets
// - control force makes control two octets
// - all-ones address accepted as command
// - transmit frames get no header prepended
// - accept-all skips address filtering
// - accept-all plus no-extract stores everything
// - single header octet fills both lanes
// - filtered: control first; else address, control
// - no-extract filtered: two octets, control first
// - unforced: one address octet if LSB one
// - unforced: unnumbered frames keep one control octet
// - check sequence octets never stored
module hrf_rx_filter #(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port
  input wire logic [hrf_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // received octets from the deframer, same clock
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_sof,
  input wire logic i_rx_eof,
  input wire logic i_rx_fcs_ok,
  input wire logic i_rx_aligned,
  // transmit octets from the xid/test buffer
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_sof,
  input wire logic i_tx_eof,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_sof,
  output logic o_tx_eof,
  // words toward memory
  output logic o_word_valid,
  output hrf_pkg::hrf_word_t o_word,
  // frame completion
  output logic o_end_valid,
  output hrf_pkg::hrf_stat_t o_stat,
  output logic [15:0] o_desc_word0,
  output logic o_bad_inc,
  output logic [23:0] o_bad_addr,
  output logic [CNT_W-1:0] o_bad_count
);
  import hrf_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // single header octet copied into both byte lanes
  function automatic hrf_word_t single_word(input logic [7:0] b);
    single_word = '{data: {b, b}, odd: 1'b0, hdr_single: 1'b1};
  endfunction

  // two octets into one word, first received octet in the low lane
  function automatic hrf_word_t pair_word(input logic [7:0] first, input logic [7:0] second);
    pair_word = '{data: {second, first}, odd: 1'b0, hdr_single: 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] mode_q, mode_d;       // header handling mode
  logic [31:0] control_status_2_q, control_status_2_d;       // filter control bits
  logic [31:0] station_q, station_d; // [15:0] local, [31:16] remote
  logic [23:0] base_q, base_d;       // init_block_base
  logic [31:0] rdata_q, rdata_d;     // read data, one cycle after strobe
  hrf_cfg_t cfg;                     // decoded configuration

  assign cfg = '{addr_ext: mode_q[MODE_ADDR_EXT_BIT], addr_force: mode_q[MODE_ADDR_FORCE_BIT],
                 ctrl_ext: mode_q[MODE_CTRL_EXT_BIT], ctrl_force: mode_q[MODE_CTRL_FORCE_BIT],
                 hdr_dis: mode_q[MODE_HDR_DIS_BIT], accept_all: control_status_2_q[CONTROL_STATUS_2_ALL_BIT],
                 global_ok: control_status_2_q[CONTROL_STATUS_2_GLOBAL_BIT]};

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  hrf_state_t state_q, state_d;     // header walk
  logic [7:0] older_q, older_d;     // oldest octet in the two-deep delay
  logic [7:0] newer_q, newer_d;     // newest octet in the delay
  logic [1:0] fill_q, fill_d;       // octets held in the delay
  logic [7:0] first_q, first_d;     // first octet of a two-octet field
  logic [7:0] pend_q, pend_d;       // payload octet waiting for its partner
  logic pend_ok_q, pend_ok_d;       // pend_q holds a byte
  logic acc_q, acc_d;               // frame accepted so far
  logic remote_q, remote_d;         // matched remote address
  logic cmd_q, cmd_d;               // matched global address
  logic [CNT_W-1:0] bad_q, bad_d;   // bad frame count
  hrf_stat_t last_q, last_d;        // flags of last accepted frame
  logic word_v_q, word_v_d;
  hrf_word_t word_q, word_d;
  logic end_v_q, end_v_d;
  logic bad_inc_q, bad_inc_d;
  logic [23:0] bad_addr_q, bad_addr_d;
  logic [15:0] desc_q, desc_d;
  logic tx_v_q, tx_sof_q, tx_eof_q;
  logic [7:0] tx_data_q;

  // octet leaving the delay is payload; the two still held at the end
  // are the check sequence and are never looked at
  logic step;                       // process older_q this cycle
  logic [7:0] oct;                  // octet under processing
  assign step = i_rx_valid && !i_rx_sof && (fill_q == 2'd2);
  assign oct = older_q;

  // ----------------------------------------------------------------
  // register port next values
  // ----------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    control_status_2_d = control_status_2_q;
    station_d = station_q;
    base_d = base_q;
    rdata_d = 32'h00000000;
    if (i_wr) begin
      case (i_addr)
        REG_MODE: mode_d = i_wdata;
        REG_CONTROL_STATUS_2: control_status_2_d = i_wdata;
        REG_STATION: station_d = i_wdata;
        REG_INIT_BASE: base_d = i_wdata[23:0];
        default: ; // unmapped or read-only: ignored
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_MODE: rdata_d = mode_q;
        REG_CONTROL_STATUS_2: rdata_d = control_status_2_q;
        REG_STATION: rdata_d = station_q;
        REG_STATUS: rdata_d = {13'h0000, last_q, {(16-CNT_W){1'b0}}, bad_q};
        REG_INIT_BASE: rdata_d = {8'h00, base_q};
        default: rdata_d = 32'h00000000; // unmapped reads as zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // header walk next values
  // ----------------------------------------------------------------
  always_comb begin
    logic two;
    logic hit_l;
    logic hit_r;
    logic hit_g;
    logic done_acc;
    two = 1'b0;
    hit_l = 1'b0;
    hit_r = 1'b0;
    hit_g = 1'b0;
    done_acc = 1'b0;
    state_d = state_q;
    older_d = older_q;
    newer_d = newer_q;
    fill_d = fill_q;
    first_d = first_q;
    pend_d = pend_q;
    pend_ok_d = pend_ok_q;
    acc_d = acc_q;
    remote_d = remote_q;
    cmd_d = cmd_q;
    bad_d = bad_q;
    last_d = last_q;
    word_v_d = 1'b0;
    word_d = word_q;
    end_v_d = 1'b0;
    bad_inc_d = 1'b0;
    bad_addr_d = bad_addr_q;
    desc_d = desc_q;
    // delay line: a new frame restarts it
    if (i_rx_valid) begin
      if (i_rx_sof) begin
        newer_d = i_rx_data;
        fill_d = 2'd1;
        state_d = ST_ADDR1;
        pend_ok_d = 1'b0;
        acc_d = 1'b0;
        remote_d = 1'b0;
        cmd_d = 1'b0;
      end else begin
        older_d = newer_q;
        newer_d = i_rx_data;
        if (fill_q != 2'd2) begin
          fill_d = fill_q + 2'd1;
        end
      end
    end
    if (step) begin
      case (state_q)
        ST_ADDR1: begin
          if (cfg.accept_all && cfg.hdr_dis) begin
            // total transparent: every octet is payload
            acc_d = 1'b1;
            pend_d = oct;
            pend_ok_d = 1'b1;
            state_d = ST_DATA;
          end else begin
            // no-extract forces a two-octet filter; leaves other misuse open
            two = cfg.hdr_dis || (cfg.addr_ext && (cfg.addr_force || !oct[0]));
            if (two) begin
              first_d = oct;
              state_d = ST_ADDR2;
            end else begin
              hit_l = (oct == station_q[7:0]);
              hit_r = (oct == station_q[23:16]);
              hit_g = cfg.global_ok && (oct == GLOBAL_OCTET);
              done_acc = 1'b1;
              if (cfg.accept_all) begin
                word_v_d = 1'b1;
                word_d = single_word(oct);
              end
            end
          end
        end
        ST_ADDR2: begin
          hit_l = ({oct, first_q} == station_q[15:0]);
          hit_r = ({oct, first_q} == station_q[31:16]);
          hit_g = cfg.global_ok && (oct == GLOBAL_OCTET) && (first_q == GLOBAL_OCTET);
          done_acc = 1'b1;
          if (cfg.accept_all) begin
            word_v_d = 1'b1;
            word_d = pair_word(first_q, oct);
          end
        end
        ST_CTRL1: begin
          // unnumbered frames end in binary 11 and stay one octet unless forced
          two = cfg.hdr_dis || (cfg.ctrl_ext && (cfg.ctrl_force || !oct[0] || !oct[1]));
          if (two) begin
            first_d = oct;
            state_d = ST_CTRL2;
          end else begin
            word_v_d = 1'b1;
            word_d = single_word(oct);
            state_d = ST_DATA;
          end
        end
        ST_CTRL2: begin
          word_v_d = 1'b1;
          word_d = pair_word(first_q, oct);
          state_d = ST_DATA;
        end
        ST_DATA: begin
          if (pend_ok_q) begin
            word_v_d = 1'b1;
            word_d = pair_word(pend_q, oct);
            pend_ok_d = 1'b0;
          end else begin
            pend_d = oct;
            pend_ok_d = 1'b1;
          end
        end
        default: ; // idle or dropping: octets fall away
      endcase
      if (done_acc) begin
        if (cfg.accept_all || hit_l || hit_r || hit_g) begin
          acc_d = 1'b1;
          remote_d = !cfg.accept_all && !hit_l && hit_r;
          cmd_d = hit_g;
          state_d = ST_CTRL1;
        end else begin
          state_d = ST_DROP;
        end
      end
    end
    // end of frame: remaining delay contents are the check sequence
    if (i_rx_valid && i_rx_eof && !i_rx_sof && state_q != ST_IDLE) begin
      state_d = ST_IDLE;
      if (!(i_rx_fcs_ok && i_rx_aligned)) begin
        bad_d = bad_q + 1'b1;
        bad_inc_d = 1'b1;
        bad_addr_d = base_q + BAD_CNT_OFFSET;
      end
      if (acc_d) begin
        // a lone trailing payload byte leaves in the low lane
        if (pend_ok_d && !word_v_d) begin
          word_v_d = 1'b1;
          word_d = '{data: {8'h00, pend_d}, odd: 1'b1, hdr_single: 1'b0};
        end
        end_v_d = 1'b1;
        last_d = '{good: i_rx_fcs_ok && i_rx_aligned, remote: remote_d, command: cmd_d};
        desc_d = 16'h0000;
        desc_d[DESC_REMOTE_BIT] = remote_d;
      end
      pend_ok_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registering; i_ce low freezes everything
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= MODE_RST;
      control_status_2_q <= CONTROL_STATUS_2_RST;
      station_q <= STATION_RST;
      base_q <= INIT_BASE_RST;
      rdata_q <= 32'h00000000;
      state_q <= ST_IDLE;
      older_q <= 8'h00;
      newer_q <= 8'h00;
      fill_q <= 2'd0;
      first_q <= 8'h00;
      pend_q <= 8'h00;
      pend_ok_q <= 1'b0;
      acc_q <= 1'b0;
      remote_q <= 1'b0;
      cmd_q <= 1'b0;
      bad_q <= '0;
      last_q <= '0;
      word_v_q <= 1'b0;
      word_q <= '0;
      end_v_q <= 1'b0;
      bad_inc_q <= 1'b0;
      bad_addr_q <= 24'h000000;
      desc_q <= 16'h0000;
      tx_v_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_sof_q <= 1'b0;
      tx_eof_q <= 1'b0;
    end else if (i_ce) begin
      mode_q <= mode_d;
      control_status_2_q <= control_status_2_d;
      station_q <= station_d;
      base_q <= base_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      older_q <= older_d;
      newer_q <= newer_d;
      fill_q <= fill_d;
      first_q <= first_d;
      pend_q <= pend_d;
      pend_ok_q <= pend_ok_d;
      acc_q <= acc_d;
      remote_q <= remote_d;
      cmd_q <= cmd_d;
      bad_q <= bad_d;
      last_q <= last_d;
      word_v_q <= word_v_d;
      word_q <= word_d;
      end_v_q <= end_v_d;
      bad_inc_q <= bad_inc_d;
      bad_addr_q <= bad_addr_d;
      desc_q <= desc_d;
      // transmit octets pass straight on, nothing prepended
      tx_v_q <= i_tx_valid;
      tx_data_q <= i_tx_data;
      tx_sof_q <= i_tx_sof;
      tx_eof_q <= i_tx_eof;
    end
  end

  assign o_rdata = rdata_q;
  assign o_word_valid = word_v_q;
  assign o_word = word_q;
  assign o_end_valid = end_v_q;
  assign o_stat = last_q;
  assign o_desc_word0 = desc_q;
  assign o_bad_inc = bad_inc_q;
  assign o_bad_addr = bad_addr_q;
  assign o_bad_count = bad_q;
  assign o_tx_valid = tx_v_q;
  assign o_tx_data = tx_data_q;
  assign o_tx_sof = tx_sof_q;
  assign o_tx_eof = tx_eof_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  bad_count_a: assert property (o_bad_inc |-> o_bad_count == $past(o_bad_count) + 1'b1)
    else $error("bad frame count did not step by one");
  drop_quiet_a: assert property (state_q == ST_DROP |=> !o_end_valid)
    else $error("dropped frame reported an end");
  all_no_drop_a: assert property (cfg.accept_all |-> state_q != ST_DROP)
    else $error("accept-all frame was dropped");
  single_lanes_a: assert property (o_word_valid && o_word.hdr_single |->
    o_word.data[15:8] == o_word.data[7:0])
    else $error("single header octet not in both lanes");
  addr_two_a: assert property (state_q == ST_ADDR2 |-> cfg.addr_ext || cfg.hdr_dis)
    else $error("second address octet without extension");
  addr_force_a: assert property (i_ce && step && state_q == ST_ADDR1 && cfg.addr_ext &&
    cfg.addr_force && !cfg.accept_all |=> state_q == ST_ADDR2)
    else $error("forced address stayed one octet");
  addr_lsb_one_a: assert property (i_ce && step && state_q == ST_ADDR1 && !cfg.addr_force &&
    !cfg.hdr_dis && oct[0] |=> state_q != ST_ADDR2)
    else $error("address with LSB one taken as two octets");
  ctrl_one_a: assert property (i_ce && step && state_q == ST_CTRL1 && !cfg.ctrl_ext &&
    !cfg.hdr_dis |=> state_q != ST_CTRL2)
    else $error("control extended while extension off");
  transp_data_a: assert property (i_ce && step && state_q == ST_ADDR1 && cfg.accept_all &&
    cfg.hdr_dis |=> state_q == ST_DATA || state_q == ST_IDLE)
    else $error("total transparent frame not sent to payload");
  remote_bit_a: assert property (o_end_valid |-> o_desc_word0[DESC_REMOTE_BIT] == o_stat.remote)
    else $error("descriptor remote bit disagrees with status");

endmodule // hrf_rx_filter

// ==== testbench/hrf_remote_station.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far station seen through the deframer: one octet per strobe
// ----------------------------------------------------------------
module hrf_remote_station (
  // clock
  input wire logic i_clk,
  // octets toward the receiver
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_sof,
  output logic o_eof,
  output logic o_fcs_ok,
  output logic o_aligned
);
  // idle line at time zero
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_sof = 1'b0;
    o_eof = 1'b0;
    o_fcs_ok = 1'b0;
    o_aligned = 1'b0;
  end

  // one frame, check octets included; gap cycles idle the strobe and
  // scramble the data so a stale octet is never mistaken for a new one
  task automatic send(input logic [7:0] q[$], input logic ok_fcs, input logic ok_aln,
                      input int gap);
    for (int i = 0; i < q.size(); i++) begin
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_data <= q[i];
      o_sof <= (i == 0);
      o_eof <= (i == q.size() - 1);
      o_fcs_ok <= ok_fcs;
      o_aligned <= ok_aln;
      for (int g = 0; g < gap; g++) begin
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_data <= ~q[i];
      end
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_sof <= 1'b0;
    o_eof <= 1'b0;
    o_data <= ~o_data;
  endtask
endmodule // hrf_remote_station

// ==== testbench/hrf_rx_filter_tb_top.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench: random modes and frames, predicted words
// ----------------------------------------------------------------
module hrf_rx_filter_tb_top;
  import hrf_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, tx_v, tx_s, tx_e, rv, rs, re, rok, ral;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] tx_d, rd8, otx_d;
  logic otx_v, otx_s, otx_e, word_v, end_v, bad_inc;
  hrf_word_t word;
  hrf_stat_t stat;
  logic [15:0] desc, bad_cnt;
  logic [23:0] bad_addr, base;
  logic [10:0] tx_prev;
  logic [17:0] got_w[$];
  logic [2:0] last_stat;
  int failures, checks_done, cyc, ends, bads, bad_exp, seed, tx_seed;

  hrf_remote_station peer_u (.i_clk(clk), .o_valid(rv), .o_data(rd8), .o_sof(rs),
    .o_eof(re), .o_fcs_ok(rok), .o_aligned(ral));
  hrf_rx_filter dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(reg_wr), .i_rd(reg_rd), .o_rdata(rdata), .i_rx_valid(rv),
    .i_rx_data(rd8), .i_rx_sof(rs), .i_rx_eof(re), .i_rx_fcs_ok(rok), .i_rx_aligned(ral),
    .i_tx_valid(tx_v), .i_tx_data(tx_d), .i_tx_sof(tx_s), .i_tx_eof(tx_e),
    .o_tx_valid(otx_v), .o_tx_data(otx_d), .o_tx_sof(otx_s), .o_tx_eof(otx_e),
    .o_word_valid(word_v), .o_word(word), .o_end_valid(end_v), .o_stat(stat),
    .o_desc_word0(desc), .o_bad_inc(bad_inc), .o_bad_addr(bad_addr), .o_bad_count(bad_cnt));

  // ----------------------------------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // a hang costs a mismatch, then the usual closing report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // register port, strobes one cycle long
  // ----------------------------------------------------------------
  task reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task reg_read(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(rdata & m, exp & m);
  endtask

  // ----------------------------------------------------------------
  // monitors: transmit passthrough and receive outputs
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst_n) begin
      tx_v <= $random(tx_seed);
      tx_s <= $random(tx_seed);
      tx_e <= $random(tx_seed);
      tx_d <= $random(tx_seed);
    end
  end

  always @(negedge clk) begin
    if (cyc > 25) check({otx_v, otx_v ? {otx_s, otx_e, otx_d} : 10'h000}, tx_prev);
    tx_prev = {tx_v, tx_v ? {tx_s, tx_e, tx_d} : 10'h000};
    if (rst_n && word_v) got_w.push_back(word);
    if (rst_n && end_v) ends++;
    if (rst_n && bad_inc) begin
      bads++;
      check(bad_addr, base + BAD_CNT_OFFSET);
    end
  end

  // ----------------------------------------------------------------
  // expected memory words for one frame (check octets left out)
  // ----------------------------------------------------------------
  task automatic predict(input logic [7:0] f[$], input hrf_cfg_t c, input logic [31:0] st,
                         output logic [17:0] w[$], output logic acc, output logic [1:0] rc);
    int al;
    int cl;
    int p;
    logic [15:0] a;
    w = {};
    acc = 1'b1;
    rc = 2'b00;
    p = 0;
    if (!(c.accept_all && c.hdr_dis)) begin
      al = (c.hdr_dis || (c.addr_ext && (c.addr_force || !f[0][0]))) ? 2 : 1;
      cl = (c.hdr_dis || (c.ctrl_ext && (c.ctrl_force || f[al][1:0] != 2'b11))) ? 2 : 1;
      a = (al == 2) ? {f[1], f[0]} : {8'h00, f[0]};
      // an all-ones address is a command even when a station address also matches
      rc[0] = c.global_ok && a == (al == 2 ? {GLOBAL_OCTET, GLOBAL_OCTET}
                                           : {8'h00, GLOBAL_OCTET});
      if (c.accept_all) w.push_back(al == 2 ? {a, 2'b00} : {f[0], f[0], 2'b01});
      else if (a == (al == 2 ? st[15:0] : {8'h00, st[7:0]})) rc[1] = 1'b0;
      else if (a == (al == 2 ? st[31:16] : {8'h00, st[23:16]})) rc[1] = 1'b1;
      else if (!rc[0]) acc = 1'b0;
      w.push_back(cl == 2 ? {f[al+1], f[al], 2'b00} : {f[al], f[al], 2'b01});
      p = al + cl;
    end
    for (; p < f.size(); p += 2)
      w.push_back(p + 1 < f.size() ? {f[p+1], f[p], 2'b00} : {8'h00, f[p], 2'b10});
  endtask

  // ----------------------------------------------------------------
  // one random mode and frame, then compare counts, flags and, on good frames, words
  // ----------------------------------------------------------------
  task automatic run_frame(input int k);
    hrf_cfg_t c;
    logic [31:0] r, st, md, cs;
    logic [15:0] t;
    logic [7:0] f[$], fq[$];
    logic [17:0] w[$];
    logic acc, bad;
    logic [1:0] rc;
    r = $random(seed);
    c = {r[0], r[0] & r[1], r[3], r[3] & r[4], r[0] & r[2], r[5], r[6]};
    st = $random(seed);
    if (k % 5 == 0) st[31:16] = st[15:0];
    t = (k % 4 == 0) ? st[15:0] : (k % 4 == 1) ? st[31:16] : (k % 4 == 2) ? 16'hFFFF : r[31:16];
    f = {t[7:0], t[15:8], r[15:8], r[23:16]};
    repeat (r[9:7]) f.push_back($random(seed));
    md = 32'h00000000;
    md[MODE_ADDR_EXT_BIT] = c.addr_ext;
    md[MODE_CTRL_EXT_BIT] = c.ctrl_ext;
    md[MODE_HDR_DIS_BIT] = c.hdr_dis;
    md[MODE_ADDR_FORCE_BIT] = c.addr_force;
    md[MODE_CTRL_FORCE_BIT] = c.ctrl_force;
    cs = 32'h00000000;
    cs[CONTROL_STATUS_2_GLOBAL_BIT] = c.global_ok;
    cs[CONTROL_STATUS_2_ALL_BIT] = c.accept_all;
    reg_write(REG_MODE, md);
    reg_write(REG_CONTROL_STATUS_2, cs);
    reg_write(REG_STATION, st);
    predict(f, c, st, w, acc, rc);
    bad = (k % 7 == 3);
    fq = f;
    fq.push_back($random(seed));
    fq.push_back($random(seed));
    got_w = {};
    ends = 0;
    bads = 0;
    peer_u.send(fq, !(bad && k[0]), !(bad && !k[0]), k % 3);
    repeat (4) @(posedge clk);
    bad_exp += bad;
    check(bads, bad);
    check(bad_cnt, bad_exp[15:0]);
    check(ends, acc);
    if (!bad) begin
      check(got_w.size(), acc ? w.size() : 0);
      for (int i = 0; i < got_w.size() && i < w.size(); i++) check(got_w[i], w[i]);
    end
    if (acc) begin
      last_stat = {!bad, rc};
      check(stat & {2'b11, !c.accept_all}, last_stat & {2'b11, !c.accept_all});
      check(desc, 16'(rc[1]) << DESC_REMOTE_BIT);
    end
    reg_read(REG_STATUS, 32'hFFFEFFFF, {13'h0000, last_stat, bad_exp[15:0]});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 70982;
    tx_seed = 70982;
    {rst_n, reg_wr, reg_rd, tx_v, tx_s, tx_e} = 6'h00;
    addr = 5'h00;
    wdata = 32'h00000000;
    tx_d = 8'h00;
    last_stat = 3'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(REG_MODE, 32'hFFFFFFFF, MODE_RST);
    reg_read(REG_CONTROL_STATUS_2, 32'hFFFFFFFF, CONTROL_STATUS_2_RST);
    reg_read(REG_STATION, 32'hFFFFFFFF, STATION_RST);
    reg_read(REG_INIT_BASE, 32'hFFFFFFFF, {8'h00, INIT_BASE_RST});
    reg_read(REG_STATUS, 32'hFFFFFFFF, 32'h00000000);
    // unmapped and read-only places keep their values
    reg_write(5'h1C, 32'hFFFFFFFF);
    reg_read(5'h1C, 32'hFFFFFFFF, 32'h00000000);
    reg_write(REG_STATUS, 32'hFFFFFFFF);
    reg_read(REG_STATUS, 32'hFFFFFFFF, 32'h00000000);
    base = $random(seed);
    reg_write(REG_INIT_BASE, {8'h00, base});
    for (int k = 0; k < 90; k++) run_frame(k);
    end_of_test();
  end
endmodule // hrf_rx_filter_tb_top
